/* rtl/rtc_main_interrupt_pin_consts.vh */
// Contract
// - Timer one pin polarity from bit zero
// - Timer one pin push-pull or open drain
// - Interrupt pin polarity from bit two
// - Interrupt pin push-pull or open drain
// - Multi-function pin polarity from bit four
// - Multi-function pin push-pull or open drain
// - Top two bits select multi-function source
// - Standby control bit governs periodic/timer enables
// - Each enabled counter tick raises periodic interrupt
// - First periodic interrupt may come early
// - All periodic enables zero suppresses periodic
// - Timer interrupts only while enable set
// - Enabled comparators compare, disabled read equal
// - Alarm forwarded only while bit six set
// - Power-fail interrupt while input low, enabled
// - Power-fail enable also enables battery detect
// - Routing bit picks multi-function or interrupt pin
// - Standby entry clears enables if control zero
// - Standby forces interrupt pins open drain
`ifndef RTC_MAIN_INTERRUPT_PIN_CONSTS_VH
`define RTC_MAIN_INTERRUPT_PIN_CONSTS_VH

// ----------------------------------------
// register word indices
// ----------------------------------------
`define REG_OUT_CFG 3'h0
`define REG_PER_EN 3'h1
`define REG_ALM_EN 3'h2
`define REG_CLK_MODE 3'h3
`define REG_ROUTE 3'h4
`define REG_STATUS 3'h5
`define REG_PINS 3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define OC_TMR1_POL 0
`define OC_TMR1_PP 1
`define OC_INT_POL 2
`define OC_INT_PP 3
`define OC_MF_POL 4
`define OC_MF_PP 5
`define OC_SEL_LO 6
`define OC_SEL_HI 7
`define PE_TMR0 6
`define PE_TMR1 7
`define AE_ALARM 6
`define AE_PWRF 7
`define CM_STBY_INT 4
`define CM_STBY_TMR 5
// only the two standby bits of clock mode are kept
`define CM_WR_MASK 8'h30

// interrupt source index, shared by routing and status
`define SRC_PWRF 0
`define SRC_PER 1
`define SRC_ALARM 2
`define SRC_TMR0 3
`define SRC_TMR1 4
`define NSRC 5

// multi-function selection codes
`define MF_SEL_INT 2'h0
`define MF_SEL_TMR0 2'h1

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_SRC 5'h00
`define RST_WORD 32'h00000000

`endif

/* rtl/sync3.v */
`timescale 1ns/1ns
// three-stage synchroniser; output moves only when stages two and three agree
module sync3
#(
    parameter RST_VAL = 1'b0
)
(
    // clock and reset
    input wire mclk,
    input wire resetn,
    // data
    input wire d,
    output reg q_r
);

reg s1_r;
reg s2_r;
reg s3_r;

always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        s1_r <= RST_VAL;
        s2_r <= RST_VAL;
        s3_r <= RST_VAL;
        q_r <= RST_VAL;
    end
    else
    begin
        s1_r <= d;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r)
            q_r <= s3_r;
    end
end

endmodule // sync3

/* rtl/pin_driver.v */
`timescale 1ns/1ns
// polarity and drive style of one output pin
module pin_driver
(
    // clock and reset
    input wire mclk,
    input wire resetn,
    // control
    input wire assert_in,
    input wire active_high,
    input wire push_pull,
    input wire force_od,
    // pin
    output reg pin_o_r,
    output reg pin_oe_r
);

wire level;

assign level = active_high ? assert_in : ~assert_in;

always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        pin_o_r <= 1'b0;
        pin_oe_r <= 1'b0;
    end
    else if (push_pull && !force_od)
    begin
        pin_o_r <= level;
        pin_oe_r <= 1'b1;
    end
    else
    begin
        // open drain: only ever pulls low, high comes from the pull-up
        pin_o_r <= 1'b0;
        pin_oe_r <= ~level;
    end
end

endmodule // pin_driver

/* rtl/rtc_interrupt_output_config.v */
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "rtc_main_interrupt_pin_consts.vh"
module rtc_interrupt_output_config
(
    // clock and reset
    input wire mclk,
    input wire resetn,
    // avalon-mm slave, word addressed
    input wire [2:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    // events from counters and timers, same clock
    input wire [5:0] counter_tick,
    input wire timer0_event,
    input wire timer1_event,
    input wire timer0_wave,
    input wire timer1_wave,
    input wire [47:0] clock_counters,
    input wire [47:0] compare_bytes,
    // asynchronous inputs
    input wire power_fail_input_n,
    input wire standby,
    input wire battery_low,
    input wire osc_buffered,
    // output pins
    output wire timer_one_output_o,
    output wire timer_one_output_oe,
    output wire main_interrupt_pin_o,
    output wire main_interrupt_pin_oe,
    output wire multi_function_output_o,
    output wire multi_function_output_oe,
    // analog control
    output reg low_batt_detect_en_r
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] out_cfg_r;
reg [7:0] per_en_r;
reg [7:0] alm_en_r;
reg [7:0] clk_mode_r;
reg [4:0] route_r;
reg [4:0] pend_r;
reg [4:0] pend_nxt;
reg standby_d_r;
reg all_eq_d_r;
reg [31:0] rd_mux;

wire pwrf_n_s;
wire standby_s;
wire batt_low_s;
wire osc_s;
wire acc_phase;
wire wr_go;
wire standby_entry;
wire stby_int_ok;
wire stby_tmr_ok;
wire [5:0] cmp_eq;
wire all_eq;
wire alarm_evt;
wire [4:0] src_set;
wire [4:0] src_gate;
wire [4:0] src_live;
wire int_assert;
wire mf_int;
wire mf_assert;
wire [1:0] mf_sel;

// ----------------------------------------
// asynchronous inputs
// ----------------------------------------
sync3 #(.RST_VAL(1'b1)) u_sync_pwrf
(
    .mclk(mclk),
    .resetn(resetn),
    .d(power_fail_input_n),
    .q_r(pwrf_n_s)
);

sync3 #(.RST_VAL(1'b0)) u_sync_stby
(
    .mclk(mclk),
    .resetn(resetn),
    .d(standby),
    .q_r(standby_s)
);

sync3 #(.RST_VAL(1'b0)) u_sync_batt
(
    .mclk(mclk),
    .resetn(resetn),
    .d(battery_low),
    .q_r(batt_low_s)
);

sync3 #(.RST_VAL(1'b0)) u_sync_osc
(
    .mclk(mclk),
    .resetn(resetn),
    .d(osc_buffered),
    .q_r(osc_s)
);

// ----------------------------------------
// bus access
// ----------------------------------------
// first edge of a request drops waitrequest, second edge completes it
assign acc_phase = (read || write) && !waitrequest;
assign wr_go = write && !waitrequest;

always @*
begin
    rd_mux = `RST_WORD;
    case (address)
        `REG_OUT_CFG: rd_mux[7:0] = out_cfg_r;
        `REG_PER_EN: rd_mux[7:0] = per_en_r;
        `REG_ALM_EN: rd_mux[7:0] = alm_en_r;
        `REG_CLK_MODE: rd_mux[7:0] = clk_mode_r;
        `REG_ROUTE: rd_mux[4:0] = route_r;
        `REG_STATUS: rd_mux[4:0] = pend_r;
        // battery flag only meaningful while detection is on
        `REG_PINS: rd_mux[3:0] = {low_batt_detect_en_r & batt_low_s, standby_s, ~pwrf_n_s, osc_s};
        default: rd_mux = `RST_WORD;
    endcase
end

always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        waitrequest <= 1'b1;
        readdata <= `RST_WORD;
    end
    else if (acc_phase)
    begin
        waitrequest <= 1'b1;
    end
    else if (read || write)
    begin
        waitrequest <= 1'b0;
        if (read)
            readdata <= rd_mux;
    end
end

// ----------------------------------------
// standby handling
// ----------------------------------------
assign standby_entry = standby_s && !standby_d_r;
assign stby_int_ok = !standby_s || clk_mode_r[`CM_STBY_INT];
assign stby_tmr_ok = stby_int_ok && (!standby_s || clk_mode_r[`CM_STBY_TMR]);

// ----------------------------------------
// configuration registers
// ----------------------------------------
always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        out_cfg_r <= `RST_BYTE;
        per_en_r <= `RST_BYTE;
        alm_en_r <= `RST_BYTE;
        clk_mode_r <= `RST_BYTE;
        route_r <= `RST_SRC;
        standby_d_r <= 1'b0;
    end
    else
    begin
        standby_d_r <= standby_s;
        if (wr_go)
        begin
            case (address)
                `REG_OUT_CFG: out_cfg_r <= writedata[7:0];
                `REG_PER_EN: per_en_r <= writedata[7:0];
                `REG_ALM_EN: alm_en_r <= writedata[7:0];
                `REG_CLK_MODE: clk_mode_r <= writedata[7:0] & `CM_WR_MASK;
                `REG_ROUTE: route_r <= writedata[4:0];
                default: ;
            endcase
        end
        // standby entry outranks a write in the same cycle
        if (standby_entry && !clk_mode_r[`CM_STBY_INT])
        begin
            per_en_r <= `RST_BYTE;
            alm_en_r[`AE_PWRF:`AE_ALARM] <= 2'h0;
        end
    end
end

// ----------------------------------------
// alarm comparators
// ----------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_cmp
        // disabled comparator reads always equal
        assign cmp_eq[gi] = !alm_en_r[gi] ||
            (clock_counters[gi*8 +: 8] == compare_bytes[gi*8 +: 8]);
    end
endgenerate

assign all_eq = &cmp_eq;
// with no comparator enabled no alarm flag can arise
assign alarm_evt = all_eq && !all_eq_d_r && (|alm_en_r[5:0]);

// ----------------------------------------
// interrupt sources
// ----------------------------------------
// ticks counted as they arrive, no realignment to the enable
assign src_set[`SRC_PER] = |(counter_tick & per_en_r[5:0]) && stby_int_ok;
assign src_set[`SRC_TMR0] = timer0_event && per_en_r[`PE_TMR0] && stby_tmr_ok;
assign src_set[`SRC_TMR1] = timer1_event && per_en_r[`PE_TMR1] && stby_tmr_ok;
assign src_set[`SRC_ALARM] = alarm_evt;
assign src_set[`SRC_PWRF] = !pwrf_n_s && alm_en_r[`AE_PWRF] && stby_int_ok;

assign src_gate[`SRC_PER] = |per_en_r[5:0] && stby_int_ok;
assign src_gate[`SRC_TMR0] = per_en_r[`PE_TMR0] && stby_tmr_ok;
assign src_gate[`SRC_TMR1] = per_en_r[`PE_TMR1] && stby_tmr_ok;
assign src_gate[`SRC_ALARM] = alm_en_r[`AE_ALARM] && stby_int_ok;
assign src_gate[`SRC_PWRF] = alm_en_r[`AE_PWRF] && stby_int_ok;

assign src_live = pend_r & src_gate;

// ----------------------------------------
// pending flags, write one to clear
// ----------------------------------------
always @*
begin
    pend_nxt = pend_r;
    if (wr_go && address == `REG_STATUS)
        pend_nxt = pend_nxt & ~writedata[4:0];
    // a new event in the clearing cycle survives
    pend_nxt = pend_nxt | src_set;
end

always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        pend_r <= `RST_SRC;
        // every comparator is off after reset, so all-equal starts high
        all_eq_d_r <= 1'b1;
        low_batt_detect_en_r <= 1'b0;
    end
    else
    begin
        pend_r <= pend_nxt;
        all_eq_d_r <= all_eq;
        low_batt_detect_en_r <= alm_en_r[`AE_PWRF];
    end
end

// ----------------------------------------
// pin routing
// ----------------------------------------
assign int_assert = |(src_live & ~route_r);
assign mf_int = |(src_live & route_r);
assign mf_sel = out_cfg_r[`OC_SEL_HI:`OC_SEL_LO];
assign mf_assert = mf_sel[1] ? osc_s :
    (mf_sel == `MF_SEL_TMR0) ? timer0_wave : mf_int;

// ----------------------------------------
// pin drivers
// ----------------------------------------
// standby drops every pin to open drain; the host side is unpowered
pin_driver u_pin_tmr1
(
    .mclk(mclk),
    .resetn(resetn),
    .assert_in(timer1_wave),
    .active_high(out_cfg_r[`OC_TMR1_POL]),
    .push_pull(out_cfg_r[`OC_TMR1_PP]),
    .force_od(standby_s),
    .pin_o_r(timer_one_output_o),
    .pin_oe_r(timer_one_output_oe)
);

pin_driver u_pin_int
(
    .mclk(mclk),
    .resetn(resetn),
    .assert_in(int_assert),
    .active_high(out_cfg_r[`OC_INT_POL]),
    .push_pull(out_cfg_r[`OC_INT_PP]),
    .force_od(standby_s),
    .pin_o_r(main_interrupt_pin_o),
    .pin_oe_r(main_interrupt_pin_oe)
);

pin_driver u_pin_mf
(
    .mclk(mclk),
    .resetn(resetn),
    .assert_in(mf_assert),
    .active_high(out_cfg_r[`OC_MF_POL]),
    .push_pull(out_cfg_r[`OC_MF_PP]),
    .force_od(standby_s),
    .pin_o_r(multi_function_output_o),
    .pin_oe_r(multi_function_output_oe)
);

endmodule // rtc_interrupt_output_config

/* verification/rtc_main_interrupt_pin_monitor.sv */
`timescale 1ns/1ns
module rtc_main_interrupt_pin_monitor (
    // clock and reset
    input logic mclk,
    input logic resetn,
    // register bus
    input logic [2:0] address,
    input logic read,
    input logic write,
    input logic [31:0] writedata,
    input logic [31:0] readdata,
    input logic waitrequest,
    // events and pins
    input logic [5:0] counter_tick,
    input logic timer1_wave,
    input logic standby,
    input logic timer_one_output_o,
    input logic timer_one_output_oe,
    input logic main_interrupt_pin_o,
    input logic main_interrupt_pin_oe,
    input logic low_batt_detect_en_r
);
// ----
// shadow of written config
// ----
logic [7:0] cfg_r;
logic pe0_r;
logic pf_en_r;
logic [3:0] quiet_r;
wire wr_done = write && !waitrequest;
// standby entry rewrites enables behind our back, so stay quiet around it
wire sb_ok = !standby && quiet_r == 4'h8;
always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        cfg_r <= 8'h00;
        pe0_r <= 1'b0;
        pf_en_r <= 1'b0;
        quiet_r <= 4'h0;
    end
    else
    begin
        if (wr_done && address == 3'h0)
            cfg_r <= writedata[7:0];
        if (wr_done && address == 3'h1)
            pe0_r <= writedata[0];
        if (wr_done && address == 3'h2)
            pf_en_r <= writedata[7];
        if (standby)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'h8)
            quiet_r <= quiet_r + 4'h1;
    end
end
// ----
// properties
// ----
default clocking cb @(posedge mclk); endclocking
default disable iff (!resetn);
sequence s_req; (read || write) && waitrequest; endsequence
sequence s_tick; counter_tick[0] && pe0_r && sb_ok; endsequence
sequence s_int_on;
    main_interrupt_pin_oe == (cfg_r[3] | ~cfg_r[2]) && main_interrupt_pin_o == (cfg_r[3] & cfg_r[2]);
endsequence
a_wait_answer: assert property (s_req |=> !waitrequest)
    else $error("bus request not answered");
a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
a_wait_idle: assert property (waitrequest && !read && !write |=> waitrequest)
    else $error("answer without request");
a_unmapped_zero: assert property (read && !waitrequest && address == 3'h7 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
a_cfg_readback: assert property (read && !waitrequest && address == 3'h0 |-> readdata == {24'h0, cfg_r})
    else $error("config readback wrong");
a_tmr1_open_drain: assert property (!$past(cfg_r[1]) |-> !timer_one_output_o)
    else $error("open drain pin driven high");
a_tmr1_level_pp: assert property (sb_ok && $past(cfg_r[1]) |-> timer_one_output_oe &&
    timer_one_output_o == ($past(timer1_wave) ~^ $past(cfg_r[0]))) else $error("timer pin level wrong");
a_tick_to_pin: assert property (s_tick |-> ##2 s_int_on)
    else $error("periodic tick not on pin");
a_lbd_follows: assert property (sb_ok |-> low_batt_detect_en_r == $past(pf_en_r))
    else $error("battery detect enable wrong");
endmodule // rtc_main_interrupt_pin_monitor
bind rtc_interrupt_output_config rtc_main_interrupt_pin_monitor i_mon (.mclk(mclk), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .counter_tick(counter_tick), .timer1_wave(timer1_wave), .standby(standby),
    .timer_one_output_o(timer_one_output_o), .timer_one_output_oe(timer_one_output_oe),
    .main_interrupt_pin_o(main_interrupt_pin_o), .main_interrupt_pin_oe(main_interrupt_pin_oe),
    .low_batt_detect_en_r(low_batt_detect_en_r));

/* verification/host_bus_model.sv */
`timescale 1ns/1ns
module host_bus_model (
    // clock
    input logic mclk,
    // avalon-mm master
    output logic [2:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    input logic [31:0] readdata,
    input logic waitrequest
);
initial
begin
    address = 3'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
end
// each access ends one edge after release, so callers never re-raise in the same step
task wr(input logic [2:0] a, input logic [31:0] d);
begin
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge mclk);
    while (waitrequest) @(posedge mclk);
    write <= 1'b0;
    @(posedge mclk);
end
endtask
task rd(input logic [2:0] a, output logic [31:0] d);
begin
    address <= a;
    read <= 1'b1;
    @(posedge mclk);
    while (waitrequest) @(posedge mclk);
    d = readdata;
    read <= 1'b0;
    @(posedge mclk);
end
endtask
endmodule // host_bus_model

/* verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
logic mclk = 1'b0;
logic resetn = 1'b0;
wire [2:0] address;
wire read, write, waitrequest, tmr1_o, tmr1_oe, int_o, int_oe, mf_o, mf_oe, lbd;
wire [31:0] writedata, readdata;
logic [5:0] counter_tick = 6'h00;
logic ev0 = 1'b0, ev1 = 1'b0, wave0 = 1'b0, wave1 = 1'b0, pf_n = 1'b1, standby = 1'b0, batt = 1'b1;
logic [47:0] counters = 48'h0, compares = 48'h0;
integer fails = 0, n_checks = 0, seed = 32'hD5F3561C, i;
integer mdl [0:7];
logic [31:0] rd_v;
logic [7:0] cfg;
always #5 mclk = ~mclk;
host_bus_model host (.mclk(mclk), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
rtc_interrupt_output_config i_rtc_interrupt_output_config (.mclk(mclk), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .counter_tick(counter_tick), .timer0_event(ev0), .timer1_event(ev1), .timer0_wave(wave0),
    .timer1_wave(wave1), .clock_counters(counters), .compare_bytes(compares), .power_fail_input_n(pf_n),
    .standby(standby), .battery_low(batt), .osc_buffered(1'b1), .timer_one_output_o(tmr1_o),
    .timer_one_output_oe(tmr1_oe), .main_interrupt_pin_o(int_o), .main_interrupt_pin_oe(int_oe),
    .multi_function_output_o(mf_o), .multi_function_output_oe(mf_oe), .low_batt_detect_en_r(lbd));
// ----
// helpers
// ----
task chk(input logic [31:0] seen, input logic [31:0] exp);
begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
        fails = fails + 1;
        $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
end
endtask
task wreg(input logic [2:0] a, input logic [7:0] d);
begin
    host.wr(a, {24'h0, d});
    mdl[a] = d;
end
endtask
task rreg(input logic [2:0] a);
begin
    host.rd(a, rd_v);
    chk(rd_v, mdl[a]);
end
endtask
// {o, oe} of a pin at a logical level
function logic [1:0] pinx(input logic lvl, input logic pp);
    pinx = pp ? {lvl, 1'b1} : {1'b0, ~lvl};
endfunction
task report_and_stop;
begin
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
end
endtask
initial
begin
    #100000;
    fails = fails + 1;
    report_and_stop;
end
// ----
// scenarios
// ----
initial
begin
    for (i = 0; i < 8; i = i + 1)
        mdl[i] = 0;
    mdl[6] = 1;
    repeat (3) @(posedge mclk);
    chk(waitrequest, 1);
    chk(readdata, 0);
    resetn <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 8; i = i + 1)
        rreg(i[2:0]);
    wreg(3'h3, 8'hFF);
    mdl[3] = 8'h30;
    rreg(3'h3);
    wreg(3'h3, 8'h00);
    for (i = 0; i < 8; i = i + 1)
    begin
        cfg = $random(seed);
        cfg[7:6] = i[1:0];
        wave1 <= $random(seed);
        wave0 <= $random(seed);
        wreg(3'h0, cfg);
        repeat (2) @(posedge mclk);
        rreg(3'h0);
        chk({tmr1_o, tmr1_oe}, pinx(wave1 ~^ cfg[0], cfg[1]));
        chk({mf_o, mf_oe}, pinx((cfg[7] | (cfg[6] & wave0)) ~^ cfg[4], cfg[5]));
    end
    wreg(3'h1, 8'h3F);
    for (i = 0; i < 6; i = i + 1)
    begin
        cfg = (i % 4) << 2;
        wreg(3'h0, cfg);
        counter_tick <= 6'h01 << i;
        @(posedge mclk);
        counter_tick <= 6'h00;
        repeat (3) @(posedge mclk);
        chk({int_o, int_oe}, pinx(cfg[2], cfg[3]));
        mdl[5] = 2;
        rreg(3'h5);
        wreg(3'h5, 8'h02);
        mdl[5] = 0;
        repeat (2) @(posedge mclk);
        chk({int_o, int_oe}, pinx(~cfg[2], cfg[3]));
    end
    wreg(3'h1, 8'h40);
    counter_tick <= 6'h3F;
    ev0 <= 1'b1;
    ev1 <= 1'b1;
    @(posedge mclk);
    counter_tick <= 6'h00;
    ev0 <= 1'b0;
    ev1 <= 1'b0;
    repeat (3) @(posedge mclk);
    mdl[5] = 8;
    rreg(3'h5);
    wreg(3'h5, 8'h1F);
    mdl[5] = 0;
    // alarm on byte 0 only; the flag rises on the step to equal
    cfg = $random(seed);
    compares <= {40'h0, cfg};
    counters <= {40'h0, ~cfg};
    wreg(3'h2, 8'h41);
    counters <= {40'h0, cfg};
    repeat (3) @(posedge mclk);
    mdl[5] = 4;
    rreg(3'h5);
    chk({int_o, int_oe}, pinx(1'b1, 1'b0));
    wreg(3'h2, 8'h01);
    repeat (2) @(posedge mclk);
    chk({int_o, int_oe}, pinx(1'b0, 1'b0));
    wreg(3'h5, 8'h04);
    mdl[5] = 0;
    // comparators stay off so only power fail can flag; it is hidden on the spare pin
    wreg(3'h0, 8'h00);
    wreg(3'h2, 8'h80);
    wreg(3'h4, 8'h01);
    pf_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(lbd, 1);
    mdl[6] = 8'h0B;
    rreg(3'h6);
    chk({mf_o, mf_oe}, pinx(1'b0, 1'b0));
    chk({int_o, int_oe}, pinx(1'b1, 1'b0));
    mdl[5] = 1;
    rreg(3'h5);
    pf_n <= 1'b1;
    repeat (8) @(posedge mclk);
    wreg(3'h5, 8'h01);
    mdl[5] = 0;
    wreg(3'h0, 8'h2A);
    wreg(3'h1, 8'hC1);
    wreg(3'h2, 8'hC0);
    standby <= 1'b1;
    repeat (8) @(posedge mclk);
    mdl[1] = 0;
    mdl[2] = 0;
    rreg(3'h1);
    rreg(3'h2);
    chk({tmr1_o, int_o, int_oe, mf_o, mf_oe}, 0);
    report_and_stop;
end
endmodule // testbench
